// >>> design/ive_pkg.sv
// Package for the interrupt enable and vector block: register address,
// field positions, source ranks and vector layout.
// Assumes a CPU core that talks over an 8-bit special-register port.
package ive_pkg;

  localparam int IVE_NUM_SRC = 15;

  // Special-register address of the enable mask
  localparam logic [7:0] IVE_ENABLE_MASK_ADDR = 8'ha8;
  localparam logic [7:0] IVE_ENABLE_MASK_RESET = 8'h00;
  // Extended enable register (one bit per rank 7..14)
  localparam logic [7:0] IVE_EXT_ENABLE_ADDR = 8'he6;
  localparam logic [7:0] IVE_EXT_ENABLE_RESET = 8'h00;
  // Read-only view of raw pending sources, low and high halves
  localparam logic [7:0] IVE_PEND_LO_ADDR = 8'he8;
  localparam logic [7:0] IVE_PEND_HI_ADDR = 8'he9;

  // Enable mask bit positions
  localparam int IVE_BIT_GLOBAL = 7;
  localparam int IVE_BIT_SPI = 6;
  localparam int IVE_BIT_TMR2 = 5;
  localparam int IVE_BIT_UART = 4;
  localparam int IVE_BIT_TMR1 = 3;
  localparam int IVE_BIT_EXT1 = 2;
  localparam int IVE_BIT_TMR0 = 1;
  localparam int IVE_BIT_EXT0 = 0;

  // Source ranks in the vector table
  localparam int IVE_RANK_EXT0 = 0;
  localparam int IVE_RANK_TMR0 = 1;
  localparam int IVE_RANK_EXT1 = 2;
  localparam int IVE_RANK_TMR1 = 3;
  localparam int IVE_RANK_UART = 4;
  localparam int IVE_RANK_TMR2 = 5;
  localparam int IVE_RANK_SPI = 6;
  localparam int IVE_RANK_SMB = 7;
  localparam int IVE_RANK_PMATCH = 8;
  localparam int IVE_RANK_ADC_WIN = 9;
  localparam int IVE_RANK_ADC_DONE = 10;
  localparam int IVE_RANK_PCA = 11;
  localparam int IVE_RANK_CMP0 = 12;
  localparam int IVE_RANK_CMP1 = 13;
  localparam int IVE_RANK_TMR3 = 14;
  // First extended rank, mapped to extended enable bit 0
  localparam int IVE_EXT_FIRST_RANK = 7;

  // Vector layout
  localparam logic [15:0] IVE_RESET_VECTOR = 16'h0000;
  localparam logic [15:0] IVE_VECTOR_BASE = 16'h0003;
  localparam int IVE_VECTOR_STEP = 8;

  // Latency figures, in system clock cycles
  localparam int IVE_DETECT_CYCLES = 1;
  localparam int IVE_CALL_CYCLES = 4;

  typedef enum logic [1:0] {
    IVE_IDLE,
    IVE_CALL,
    IVE_IN_SERVICE
  } ive_state_t;

  // Register port from the core
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ive_reg_req_t;

  // Call request to the core
  typedef struct packed {
    logic req;
    logic [3:0] rank;
    logic [15:0] vector;
  } ive_call_t;

  // Peripheral flag group of one source with up to two flags
  typedef struct packed {
    logic [1:0] flag;
    logic [1:0] aux_en;
  } ive_src_flags_t;

endpackage

// >>> design/ive_prio_enc.sv
// Fixed-order priority encoder: lowest set index wins.
// Assumes a request vector that is stable within one clock.
`timescale 1ns/1ps
module ive_prio_enc #(
  parameter int WIDTH = 15,
  parameter int IDX_W = 4
) (
  // Requests
  input wire logic [WIDTH-1:0] req,
  // Result
  output logic any,
  output logic [IDX_W-1:0] idx
);

  always_comb begin
    any = 1'b0;
    idx = '0;
    for (int i = WIDTH - 1; i >= 0; i--) begin
      if (req[i]) begin
        any = 1'b1;
        idx = IDX_W'(i);
      end
    end
  end

endmodule

// >>> design/ive_top.sv
// Interrupt enable gating and vector selection for the 8-bit core.
// Assumes peripheral flags and the register port are in the mclk domain;
// the external inputs arrive from pins and are synchronised here.
// Operation
// - Global enable bit 7 at 0 blocks every request.
// - Global enable at 1 forwards each source by its own mask or extended enable bit.
// - Bit 6 gates all serial peripheral interface requests.
// - Bit 5 gates timer two, passing low or high overflow flags.
// - Bit 4 gates the UART request.
// - Bit 3 gates timer one overflow; bit 1 gates timer zero overflow.
// - Bit 2 gates external input one; bit 0 gates external input zero.
// - Timer two vectors to 0x002B, rank 5, flags qualified by aux enables.
// - Timer three vectors to 0x0073, rank 14, aux-qualified like timer two.
// - Conversion done vectors to 0x0053, rank 10, extended enable bit.
// - Equal-level requests are served lowest rank first.
// - Pending flags set regardless of mask and extended enables; masking only blocks.
// - Sampled every cycle; fastest response is detect plus four call cycles.
`timescale 1ns/1ps
module ive_top
  import ive_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Register port from the core
  input wire ive_pkg::ive_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  // External inputs from pins, active high request level
  input wire logic external_input_zero,
  input wire logic external_input_one,
  // Timer flags and aux enables
  input wire logic timer_zero_overflow_flag,
  input wire logic timer_one_overflow_flag,
  input wire logic timer_two_low_overflow_flag,
  input wire logic timer_two_high_overflow_flag,
  input wire logic timer_two_low_irq_aux_enable,
  input wire logic timer_two_capture_irq_aux_enable,
  input wire ive_pkg::ive_src_flags_t timer_three_flags,
  // Other peripheral flags
  input wire logic uart_flag,
  input wire logic spi_flag,
  input wire logic smbus_flag,
  input wire logic port_match_flag,
  input wire logic adc_window_flag,
  input wire logic conversion_done_flag,
  input wire logic pca_flag,
  input wire logic cmp0_flag,
  input wire logic cmp1_flag,
  // Core handshake
  input wire logic instr_boundary,
  input wire logic reti_done,
  // Call to the core
  output ive_pkg::ive_call_t call_out,
  output logic in_service,
  output logic [IVE_NUM_SRC-1:0] pending_view
);

  import ive_pkg::*;

  logic [7:0] interrupt_enable_mask;
  logic [7:0] ext_enable;
  logic [1:0] ext0_sync;
  logic [1:0] ext1_sync;
  logic [IVE_NUM_SRC-1:0] pend_q;
  ive_state_t state;
  logic [1:0] call_cnt;

  // Enable fields
  wire global_irq_enable = interrupt_enable_mask[IVE_BIT_GLOBAL];
  wire serial_periph_irq_enable = interrupt_enable_mask[IVE_BIT_SPI];
  wire timer_two_irq_enable = interrupt_enable_mask[IVE_BIT_TMR2];
  wire uart_irq_enable = interrupt_enable_mask[IVE_BIT_UART];
  wire timer_one_irq_enable = interrupt_enable_mask[IVE_BIT_TMR1];
  wire ext_input_one_irq_enable = interrupt_enable_mask[IVE_BIT_EXT1];
  wire timer_zero_irq_enable = interrupt_enable_mask[IVE_BIT_TMR0];
  wire ext_input_zero_irq_enable = interrupt_enable_mask[IVE_BIT_EXT0];
  wire conversion_done_irq_enable =
    ext_enable[IVE_RANK_ADC_DONE - IVE_EXT_FIRST_RANK];

  // Aux-qualified timer requests
  wire tmr2_raw = (timer_two_low_overflow_flag &
                   timer_two_low_irq_aux_enable) |
                  (timer_two_high_overflow_flag &
                   timer_two_capture_irq_aux_enable);
  wire tmr3_raw = |(timer_three_flags.flag &
                    timer_three_flags.aux_en);

  // Raw pending view, independent of the mask and extended enables
  logic [IVE_NUM_SRC-1:0] raw_pend;
  always_comb begin
    raw_pend = '0;
    raw_pend[IVE_RANK_EXT0] = ext0_sync[1];
    raw_pend[IVE_RANK_TMR0] = timer_zero_overflow_flag;
    raw_pend[IVE_RANK_EXT1] = ext1_sync[1];
    raw_pend[IVE_RANK_TMR1] = timer_one_overflow_flag;
    raw_pend[IVE_RANK_UART] = uart_flag;
    raw_pend[IVE_RANK_TMR2] = tmr2_raw;
    raw_pend[IVE_RANK_SPI] = spi_flag;
    raw_pend[IVE_RANK_SMB] = smbus_flag;
    raw_pend[IVE_RANK_PMATCH] = port_match_flag;
    raw_pend[IVE_RANK_ADC_WIN] = adc_window_flag;
    raw_pend[IVE_RANK_ADC_DONE] = conversion_done_flag;
    raw_pend[IVE_RANK_PCA] = pca_flag;
    raw_pend[IVE_RANK_CMP0] = cmp0_flag;
    raw_pend[IVE_RANK_CMP1] = cmp1_flag;
    raw_pend[IVE_RANK_TMR3] = tmr3_raw;
  end

  // Per-source mask
  logic [IVE_NUM_SRC-1:0] src_en;
  always_comb begin
    src_en = '0;
    src_en[IVE_RANK_EXT0] = ext_input_zero_irq_enable;
    src_en[IVE_RANK_TMR0] = timer_zero_irq_enable;
    src_en[IVE_RANK_EXT1] = ext_input_one_irq_enable;
    src_en[IVE_RANK_TMR1] = timer_one_irq_enable;
    src_en[IVE_RANK_UART] = uart_irq_enable;
    src_en[IVE_RANK_TMR2] = timer_two_irq_enable;
    src_en[IVE_RANK_SPI] = serial_periph_irq_enable;
    src_en[IVE_RANK_TMR3:IVE_EXT_FIRST_RANK] = ext_enable;
    src_en[IVE_RANK_ADC_DONE] = conversion_done_irq_enable;
  end

  // Masking blocks requests only; pending is never touched
  wire [IVE_NUM_SRC-1:0] gated =
    pend_q & src_en & {IVE_NUM_SRC{global_irq_enable}};

  wire any_req;
  wire [3:0] win_rank;
  ive_prio_enc #(
    .WIDTH(IVE_NUM_SRC),
    .IDX_W(4)
  ) u_prio (
    .req(gated),
    .any(any_req),
    .idx(win_rank)
  );

  // Vector of the winning rank
  wire [15:0] win_vector =
    IVE_VECTOR_BASE + 16'(win_rank) * 16'(IVE_VECTOR_STEP);

  // Register decode
  wire wr_ie = reg_req.wr && reg_req.addr == IVE_ENABLE_MASK_ADDR;
  wire wr_eie = reg_req.wr && reg_req.addr == IVE_EXT_ENABLE_ADDR;
  wire [7:0] next_rdata =
    (reg_req.addr == IVE_ENABLE_MASK_ADDR) ? interrupt_enable_mask :
    (reg_req.addr == IVE_EXT_ENABLE_ADDR) ? ext_enable :
    (reg_req.addr == IVE_PEND_LO_ADDR) ? pend_q[7:0] :
    (reg_req.addr == IVE_PEND_HI_ADDR) ? {1'b0, pend_q[14:8]} :
    8'h00;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      interrupt_enable_mask <= IVE_ENABLE_MASK_RESET;
      ext_enable <= IVE_EXT_ENABLE_RESET;
      reg_rdata <= 8'h00;
    end else begin
      if (wr_ie)
        interrupt_enable_mask <= reg_req.wdata;
      if (wr_eie)
        ext_enable <= reg_req.wdata;
      reg_rdata <= reg_req.rd ? next_rdata : 8'h00;
    end
  end

  // Pin synchronisers, second stage only is read
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ext0_sync <= 2'b00;
      ext1_sync <= 2'b00;
    end else begin
      ext0_sync <= {ext0_sync[0], external_input_zero};
      ext1_sync <= {ext1_sync[0], external_input_one};
    end
  end

  // Detect stage: sampled every cycle
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b)
      pend_q <= '0;
    else
      pend_q <= raw_pend;
  end

  // Call sequencer; no call while a routine runs, since only one
  // level is modelled here
  wire start_call = state == IVE_IDLE && any_req && instr_boundary;
  wire [1:0] last_call = 2'(IVE_CALL_CYCLES - 1);

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      state <= IVE_IDLE;
      call_cnt <= 2'b00;
      call_out <= '0;
      in_service <= 1'b0;
    end else begin
      case (state)
        IVE_IDLE: begin
          if (start_call) begin
            state <= IVE_CALL;
            call_cnt <= 2'b00;
            call_out.req <= 1'b1;
            call_out.rank <= win_rank;
            call_out.vector <= win_vector;
          end
        end
        IVE_CALL: begin
          // Four-cycle call to the vector
          if (call_cnt == last_call) begin
            state <= IVE_IN_SERVICE;
            call_out.req <= 1'b0;
            in_service <= 1'b1;
          end else begin
            call_cnt <= call_cnt + 2'b01;
          end
        end
        IVE_IN_SERVICE: begin
          if (reti_done) begin
            state <= IVE_IDLE;
            in_service <= 1'b0;
          end
        end
        default: state <= IVE_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b)
      pending_view <= '0;
    else
      pending_view <= pend_q;
  end

endmodule

// >>> verification/ive_asserts.sv
// Checker for the interrupt enable and vector block.
// Bound to ive_top; sees only its ports.
`timescale 1ns/1ps
module ive_asserts
  import ive_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Register port
  input wire ive_pkg::ive_reg_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  // Flag and core handshake
  input wire logic timer_zero_overflow_flag,
  input wire logic reti_done,
  // Call side
  input wire ive_pkg::ive_call_t call_out,
  input wire logic in_service,
  input wire logic [IVE_NUM_SRC-1:0] pending_view
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);
  // Shadow of the mask, rebuilt from observed writes
  logic [7:0] ie;
  wire ie_wr = reg_req.wr && reg_req.addr == 8'ha8;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) ie <= 8'h00;
    else if (ie_wr) ie <= reg_req.wdata;
  end
  global_block_a: assert property (
    !ie[7] && !call_out.req |=> !call_out.req)
    else $error("call raised with global enable clear");
  mask_read_a: assert property (
    reg_req.rd && !reg_req.wr && reg_req.addr == 8'ha8 |=> reg_rdata == ie)
    else $error("mask read back wrong");
  call_len_a: assert property (
    $rose(call_out.req) |-> call_out.req[*4] ##1 !call_out.req)
    else $error("call request not four cycles");
  vec_map_a: assert property (
    call_out.req |-> call_out.vector ==
      IVE_VECTOR_BASE + 16'(call_out.rank) * 16'(IVE_VECTOR_STEP))
    else $error("vector does not match rank");
  svc_start_a: assert property ($fell(call_out.req) |-> in_service)
    else $error("service not entered after call");
  svc_block_a: assert property (in_service |-> !call_out.req)
    else $error("call while in service");
  reti_end_a: assert property (in_service && reti_done |=> !in_service)
    else $error("service not left on return");
  pend_flag_a: assert property (
    timer_zero_overflow_flag[*3] |-> pending_view[IVE_RANK_TMR0])
    else $error("pending view misses flag");
  cover property ($rose(call_out.req));
  cover property (in_service && reti_done);
  cover property (ie_wr && reg_req.wdata[7]);
endmodule

bind ive_top ive_asserts i_ive_asserts (
  .mclk(mclk), .rst_b(rst_b), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .timer_zero_overflow_flag(timer_zero_overflow_flag),
  .reti_done(reti_done), .call_out(call_out), .in_service(in_service),
  .pending_view(pending_view)
);

// >>> verification/ive_core_model.sv
// Core model: instruction boundaries and return from service.
// Slow mode skips every other boundary and stretches the routine.
`timescale 1ns/1ps
module ive_core_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // From the block and bench
  input wire logic in_service,
  input wire logic slow,
  // To the block
  output logic instr_boundary,
  output logic reti_done
);
  logic [3:0] cnt;
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      cnt <= 4'h0;
      instr_boundary <= 1'b0;
      reti_done <= 1'b0;
    end else begin
      cnt <= (in_service && !reti_done) ? cnt + 4'h1 : 4'h0;
      instr_boundary <= slow ? !instr_boundary : 1'b1;
      reti_done <= in_service && !reti_done && cnt == (slow ? 4'hc : 4'h2);
    end
  end
endmodule

// >>> verification/testbench.sv
// Bench for the interrupt enable and vector block.
// Flags and register port driven here; the core model answers calls.
`timescale 1ns/1ps
module testbench;
  import ive_pkg::*;
  logic mclk, rst_b, t2h, slow, instr_boundary, reti_done, in_service;
  ive_reg_req_t reg_req;
  ive_call_t call_out;
  logic [14:0] fl, pending_view;
  logic [3:0] aux;
  logic [7:0] reg_rdata;
  int num_errors = 0;
  int samples_checked = 0;
  int r;
  ive_top i_ive_top (
    .mclk(mclk), .rst_b(rst_b), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .external_input_zero(fl[0]), .external_input_one(fl[2]),
    .timer_zero_overflow_flag(fl[1]), .timer_one_overflow_flag(fl[3]),
    .timer_two_low_overflow_flag(fl[5]), .timer_two_high_overflow_flag(t2h),
    .timer_two_low_irq_aux_enable(aux[0]),
    .timer_two_capture_irq_aux_enable(aux[1]),
    .timer_three_flags({1'b0, fl[14], aux[3:2]}),
    .uart_flag(fl[4]), .spi_flag(fl[6]), .smbus_flag(fl[7]),
    .port_match_flag(fl[8]), .adc_window_flag(fl[9]),
    .conversion_done_flag(fl[10]), .pca_flag(fl[11]),
    .cmp0_flag(fl[12]), .cmp1_flag(fl[13]),
    .instr_boundary(instr_boundary), .reti_done(reti_done),
    .call_out(call_out), .in_service(in_service), .pending_view(pending_view)
  );
  ive_core_model i_ive_core_model (.mclk(mclk), .rst_b(rst_b),
    .in_service(in_service), .slow(slow),
    .instr_boundary(instr_boundary), .reti_done(reti_done));
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk) reg_req <= '{1'b1, 1'b0, a, d};
    @(posedge mclk) reg_req <= '0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge mclk) reg_req <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge mclk) reg_req <= '0;
    #1 chk(16'(reg_rdata), 16'(e));
  endtask
  task automatic no_req();
    repeat (8) begin
      @(posedge mclk);
      #1 chk(16'(call_out.req), 16'h0);
    end
  endtask
  task automatic see_call(input int k);
    for (int i = 0; i < 12 && call_out.req !== 1'b1; i++) @(posedge mclk) #1;
    chk(16'(call_out.req), 16'h1);
    chk(16'(call_out.rank), 16'(k));
    chk(call_out.vector, 16'h0003 + 16'(8 * k));
  endtask
  task automatic idle();
    for (int i = 0; i < 40 && (in_service | call_out.req) !== 1'b0; i++)
      @(posedge mclk) #1;
    chk(16'(in_service), 16'h0);
  endtask
  task automatic final_report();
    if (num_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge mclk);
    num_errors++;
    final_report();
  end
  initial begin
    rst_b = 1'b0;
    reg_req = '0;
    fl = '0;
    aux = 4'hf;
    t2h = 1'b0;
    slow = 1'b0;
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    rd(8'ha8, 8'h00);
    rd(8'he6, 8'h00);
    wr(8'ha8, 8'h5a);
    rd(8'ha8, 8'h5a);
    rd(8'h10, 8'h00);
    wr(8'he6, 8'hff);
    wr(8'ha8, 8'h7f);
    @(posedge mclk) fl <= 15'h7fff;
    no_req();
    chk(16'(pending_view), 16'h7fff);
    rd(8'he8, 8'hff);
    rd(8'he9, 8'h7f);
    @(posedge mclk) fl <= 15'h0418;
    no_req();
    wr(8'ha8, 8'hff);
    see_call(3);
    @(posedge mclk) fl <= '0;
    idle();
    // Masked first, then unmasked while the flag stays up
    for (r = 0; r < 15; r++) begin
      slow <= r[0];
      if (r < 7) wr(8'ha8, 8'hff ^ 8'(1 << r));
      else wr(8'he6, 8'hff ^ 8'(1 << (r - 7)));
      @(posedge mclk) fl <= 15'(1 << r);
      no_req();
      chk(16'(pending_view), 16'(1 << r));
      if (r < 7) begin
        wr(8'he6, 8'h00);
        wr(8'ha8, 8'h80 | 8'(1 << r));
      end else begin
        wr(8'ha8, 8'h80);
        wr(8'he6, 8'(1 << (r - 7)));
      end
      see_call(r);
      @(posedge mclk) fl <= '0;
      idle();
    end
    // Auxiliary enables hold back timer two and three
    @(posedge mclk) aux <= 4'h0;
    wr(8'he6, 8'h80);
    wr(8'ha8, 8'ha0);
    @(posedge mclk) fl <= 15'h4000;
    t2h <= 1'b1;
    no_req();
    @(posedge mclk) aux <= 4'h2;
    see_call(5);
    @(posedge mclk) t2h <= 1'b0;
    idle();
    @(posedge mclk) aux <= 4'h4;
    see_call(14);
    @(posedge mclk) fl <= '0;
    idle();
    final_report();
  end
endmodule
